// >>> shared/hpp_pkg.sv
// shared constants and types for the host processor port
package hpp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  // address bit that selects memory space over control register space
  localparam int MEM_SEL_BIT = 13;
  // device input vector layout: {cs_n, rw_wr_n, data_strobe_or_read_strobe_n, bus_style, addr, data}
  localparam int DEV_IN_W = 4 + ADDR_W + DATA_W;
  localparam int POS_DATA = 0;
  localparam int POS_ADDR = DATA_W;
  localparam int POS_STYLE = DATA_W + ADDR_W;
  localparam int POS_DS = POS_STYLE + 1;
  localparam int POS_RW = POS_STYLE + 2;
  localparam int POS_CS = POS_STYLE + 3;
  // host input vector layout: {ack, data}
  localparam int HOST_IN_W = 1 + DATA_W;
  localparam int POS_ACK = DATA_W;
  // idle cycles the host leaves between accesses so both ends see the release
  localparam logic [3:0] HOST_GAP_CYC = 4'h8;
  localparam logic [3:0] GAP_ZERO = 4'h0;
  localparam logic [3:0] GAP_ONE = 4'h1;
  // bus style levels
  localparam logic STYLE_STROBE_DIR = 1'b1;
  localparam logic STYLE_SEPARATE = 1'b0;
  // acknowledge idle and done levels per style
  localparam logic ACK_HIGH = 1'b1;
  localparam logic ACK_LOW = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  typedef enum logic [1:0] {DEV_IDLE, DEV_ACCESS, DEV_DONE} dev_state_type;
  typedef enum logic [1:0] {HOST_IDLE, HOST_SETUP, HOST_WAIT, HOST_GAP} host_state_type;
endpackage : hpp_pkg

// >>> shared/hpp_if.sv
// pin-level interface joining the host end and the device end
`timescale 1ns/10ps
interface hpp_if;
  import hpp_pkg::*;
  logic cs_n;
  logic rw_wr_n;
  logic data_strobe_or_read_strobe_n;
  logic bus_style;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data_o;
  logic host_data_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic dev_ack_o;
  logic dev_ack_oe;
  logic [DATA_W-1:0] host_data_lines;
  logic transfer_acknowledge;
  // resolved data bus, undriven lines read as zero
  assign host_data_lines = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : DATA_ZERO);
  // resolved acknowledge: pull-up in strobe style, pull-down in separate style
  assign transfer_acknowledge = dev_ack_oe ? dev_ack_o : bus_style;
  modport device (
    input cs_n, rw_wr_n, data_strobe_or_read_strobe_n, bus_style, addr, host_data_lines,
    output dev_data_o, dev_data_oe, dev_ack_o, dev_ack_oe
  );
  modport host (
    input transfer_acknowledge, host_data_lines,
    output cs_n, rw_wr_n, data_strobe_or_read_strobe_n, bus_style, addr, host_data_o, host_data_oe
  );
endinterface : hpp_if

// >>> hw/hpp_device.sv
// device end of the asynchronous host processor port
`timescale 1ns/10ps
module hpp_device
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pins
  hpp_if.device port,
  // internal register and memory access
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic o_acc_mem,
  output logic [ADDR_W-1:0] o_acc_addr,
  output logic [DATA_W-1:0] o_acc_wdata,
  input wire logic i_acc_done,
  input wire logic [DATA_W-1:0] i_acc_rdata
);

  // all state of the device end in one record: s1 to s3 are the pin synchroniser
  // stages, f the filtered pin word that the sequencer acts on
  typedef struct packed {
    logic [DEV_IN_W-1:0] s1;
    logic [DEV_IN_W-1:0] s2;
    logic [DEV_IN_W-1:0] s3;
    logic [DEV_IN_W-1:0] f;
    dev_state_type st;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic acc_valid;
    logic data_oe;
    logic ack;
    logic ack_oe;
  } dev_reg_type;

  dev_reg_type r_q;
  dev_reg_type r_d;
  logic [DEV_IN_W-1:0] pins_in;
  logic sel;
  logic style;
  logic ds_low;
  logic wr_low;
  logic strobe_act;
  logic ack_idle_lvl;
  logic ack_done_lvl;

  // pin levels of an idle, deselected host; the filter starts from these so that
  // leaving reset never looks like a strobe with chip select low
  localparam logic [DEV_IN_W-1:0] PINS_IDLE = {1'b1, 1'b1, 1'b1, STYLE_STROBE_DIR,
    ADDR_ZERO, DATA_ZERO};

  // gather the pins into one vector for the synchroniser
  // address and data ride with the strobes, so all come from one filtered word
  assign pins_in = {port.cs_n, port.rw_wr_n, port.data_strobe_or_read_strobe_n, port.bus_style,
                    port.addr, port.host_data_lines};

  // filtered pin views; the logic acts only on the filtered word,
  // so a change seen by one stage alone starts nothing
  assign sel = ~r_q.f[POS_CS];
  assign style = r_q.f[POS_STYLE];
  assign ds_low = ~r_q.f[POS_DS];
  assign wr_low = ~r_q.f[POS_RW];
  assign strobe_act = (style == STYLE_STROBE_DIR) ? ds_low : (ds_low | wr_low);

  // acknowledge levels of the selected style: idle, and completion
  // the completion level is the inverse of the idle level in either style
  assign ack_idle_lvl = (style == STYLE_STROBE_DIR) ? ACK_HIGH : ACK_LOW;
  assign ack_done_lvl = ~ack_idle_lvl;

  // next-state logic
  always_comb
  begin
    r_d = r_q;
    r_d.s1 = pins_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    // a change counts once the second and third stages agree
    if (r_q.s2 == r_q.s3)
    begin
      r_d.f = r_q.s3;
    end
    // the request pulse lasts one cycle; the acknowledge enable follows select
    r_d.acc_valid = 1'b0;
    r_d.ack_oe = sel;
    // access sequencer: idle, waiting on the internal side, holding the answer
    case (r_q.st)
      DEV_IDLE:
      begin
        // strobe style: the direction level picks write or read
        if (sel && (style == STYLE_STROBE_DIR) && ds_low)
        begin
          r_d.wr = wr_low;
          r_d.st = DEV_ACCESS;
        end
        // separate style: a write wins when both strobes are low together
        else if (sel && (style == STYLE_SEPARATE) && wr_low)
        begin
          r_d.wr = 1'b1;
          r_d.st = DEV_ACCESS;
        end
        else if (sel && (style == STYLE_SEPARATE) && ds_low)
        begin
          r_d.wr = 1'b0;
          r_d.st = DEV_ACCESS;
        end
        // address and write data come from the same filtered word as the strobe
        if (r_d.st == DEV_ACCESS)
        begin
          r_d.addr = r_q.f[POS_ADDR +: ADDR_W];
          r_d.wdata = r_q.f[POS_DATA +: DATA_W];
          r_d.acc_valid = 1'b1;
          // acknowledge shows "not yet done"
          r_d.ack = ack_idle_lvl;
        end
      end
      DEV_ACCESS:
      begin
        // the internal side may take any number of cycles; the host just waits
        // a host that drops select meanwhile still lets the internal access end
        if (i_acc_done)
        begin
          r_d.rdata = i_acc_rdata;
          r_d.data_oe = ~r_q.wr & sel;
          // completion: low in strobe style, rising in separate style
          r_d.ack = ack_done_lvl;
          r_d.st = DEV_DONE;
        end
      end
      DEV_DONE:
      begin
        // read data stays put until the strobe or select goes away
        // in separate style either strobe still low keeps the answer up
        if (!strobe_act || !sel)
        begin
          r_d.data_oe = 1'b0;
          r_d.ack = ack_idle_lvl;
          r_d.st = DEV_IDLE;
        end
      end
      default:
      begin
        // an unused state code returns to idle without touching the bus
        r_d.st = DEV_IDLE;
      end
    endcase
    // never drive the bus while deselected
    // this also covers a host that deselects during an internal access
    if (!sel)
    begin
      r_d.data_oe = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      r_q <= '0;
      // the filter holds idle pin levels, so no access starts out of reset
      r_q.s1 <= PINS_IDLE;
      r_q.s2 <= PINS_IDLE;
      r_q.s3 <= PINS_IDLE;
      r_q.f <= PINS_IDLE;
      r_q.st <= DEV_IDLE;
      r_q.ack <= ACK_HIGH;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // pin drivers
  // the acknowledge enable follows filtered select; deselected, the line takes its pull level
  // read data reaches the bus only while its enable is high
  assign port.dev_data_o = r_q.rdata;
  assign port.dev_data_oe = r_q.data_oe;
  assign port.dev_ack_o = r_q.ack;
  assign port.dev_ack_oe = r_q.ack_oe;

  // internal access port
  // address and data stay put from the valid pulse until the next access
  assign o_acc_valid = r_q.acc_valid;
  assign o_acc_write = r_q.wr;
  assign o_acc_mem = r_q.addr[MEM_SEL_BIT];
  assign o_acc_addr = r_q.addr;
  assign o_acc_wdata = r_q.wdata;

endmodule : hpp_device

// >>> hw/hpp_host.sv
// host end of the asynchronous host processor port
`timescale 1ns/10ps
module hpp_host
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // user request side
  input wire logic i_bus_style,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // pins
  hpp_if.host port
);

  typedef struct packed {
    logic [HOST_IN_W-1:0] s1;
    logic [HOST_IN_W-1:0] s2;
    logic [HOST_IN_W-1:0] s3;
    logic [HOST_IN_W-1:0] f;
    host_state_type st;
    logic style;
    logic wr;
    logic cs_n;
    logic rw_wr_n;
    logic data_strobe_or_read_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic seen_low;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic busy;
    logic [3:0] gap;
  } host_reg_type;

  host_reg_type r_q;
  host_reg_type r_d;
  logic ack_f;

  assign ack_f = r_q.f[POS_ACK];

  // next-state logic
  always_comb
  begin
    r_d = r_q;
    r_d.s1 = {port.transfer_acknowledge, port.host_data_lines};
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 == r_q.s3)
    begin
      r_d.f = r_q.s3;
    end
    r_d.done = 1'b0;
    r_d.style = i_bus_style;
    case (r_q.st)
      HOST_IDLE:
      begin
        if (i_req)
        begin
          r_d.busy = 1'b1;
          r_d.wr = i_write;
          r_d.addr = i_addr;
          r_d.wdata = i_wdata;
          r_d.cs_n = 1'b0;
          // direction level high for reads in strobe style, idle high otherwise
          r_d.rw_wr_n = (r_q.style == STYLE_STROBE_DIR) ? ~i_write : 1'b1;
          r_d.data_oe = i_write;
          r_d.st = HOST_SETUP;
        end
      end
      HOST_SETUP:
      begin
        r_d.seen_low = 1'b0;
        if ((r_q.style == STYLE_SEPARATE) && r_q.wr)
        begin
          r_d.rw_wr_n = 1'b0;
        end
        else
        begin
          r_d.data_strobe_or_read_strobe_n = 1'b0;
        end
        r_d.st = HOST_WAIT;
      end
      HOST_WAIT:
      begin
        if (!ack_f)
        begin
          r_d.seen_low = 1'b1;
        end
        // strobe style waits for low; separate style waits for a rising edge
        if (((r_q.style == STYLE_STROBE_DIR) && !ack_f) ||
            ((r_q.style == STYLE_SEPARATE) && ack_f && r_q.seen_low))
        begin
          r_d.rdata = r_q.f[POS_DATA +: DATA_W];
          r_d.done = 1'b1;
          r_d.cs_n = 1'b1;
          r_d.data_strobe_or_read_strobe_n = 1'b1;
          r_d.rw_wr_n = 1'b1;
          r_d.data_oe = 1'b0;
          r_d.gap = HOST_GAP_CYC;
          r_d.st = HOST_GAP;
        end
      end
      HOST_GAP:
      begin
        r_d.gap = r_q.gap - GAP_ONE;
        if (r_q.gap == GAP_ONE)
        begin
          r_d.busy = 1'b0;
          r_d.st = HOST_IDLE;
        end
      end
      default:
      begin
        r_d.st = HOST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      r_q <= '0;
      r_q.st <= HOST_IDLE;
      r_q.cs_n <= 1'b1;
      r_q.rw_wr_n <= 1'b1;
      r_q.data_strobe_or_read_strobe_n <= 1'b1;
      r_q.style <= STYLE_STROBE_DIR;
      r_q.gap <= GAP_ZERO;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // pin drivers
  assign port.cs_n = r_q.cs_n;
  assign port.rw_wr_n = r_q.rw_wr_n;
  assign port.data_strobe_or_read_strobe_n = r_q.data_strobe_or_read_strobe_n;
  assign port.bus_style = r_q.style;
  assign port.addr = r_q.addr;
  assign port.host_data_o = r_q.wdata;
  assign port.host_data_oe = r_q.data_oe;

  // user outputs
  assign o_busy = r_q.busy;
  assign o_done = r_q.done;
  assign o_rdata = r_q.rdata;

endmodule : hpp_host

// >>> verif/hpp_port_properties.sv
// concurrent checks on the wires between host and device ends
`timescale 1ns/10ps
module hpp_port_properties
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // port wires
  input wire logic cs_n,
  input wire logic rw_wr_n,
  input wire logic data_strobe_or_read_strobe_n,
  input wire logic bus_style,
  input wire logic host_data_oe,
  input wire logic [DATA_W-1:0] dev_data_o,
  input wire logic dev_data_oe,
  input wire logic dev_ack_o,
  input wire logic dev_ack_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // strobe active and write-only phase, per bus style
  wire strobe_on = !cs_n && (!data_strobe_or_read_strobe_n || (!bus_style && !rw_wr_n));
  wire wr_only = bus_style ? !rw_wr_n : data_strobe_or_read_strobe_n;
  // acknowledge at completion level, and start of an access
  sequence ack_done_s;
    dev_ack_oe && (dev_ack_o != bus_style);
  endsequence
  sequence start_s;
    !cs_n && ($fell(data_strobe_or_read_strobe_n) || (!bus_style && $fell(rw_wr_n)));
  endsequence
  deselect_release_a: assert property (cs_n [*8] |-> !dev_data_oe && !dev_ack_oe)
    else $error("device drives while deselected");
  select_ack_a: assert property ((!cs_n) [*8] |-> dev_ack_oe)
    else $error("acknowledge not driven while selected");
  write_no_drive_a: assert property (wr_only [*8] |-> !dev_data_oe)
    else $error("device drives data outside a read");
  ack_idle_a: assert property ((!strobe_on) [*8] |-> !dev_ack_oe || dev_ack_o == bus_style)
    else $error("acknowledge not at idle level");
  data_with_ack_a: assert property ($rose(dev_data_oe) |-> ack_done_s)
    else $error("read data without acknowledge");
  data_hold_a: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_o))
    else $error("read data changed while driven");
  ack_hold_a: assert property (ack_done_s ##1 strobe_on |-> ack_done_s)
    else $error("acknowledge dropped before strobe release");
  answer_time_a: assert property (start_s |-> ##[1:40] ack_done_s)
    else $error("access not acknowledged in time");
  no_fight_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data bus");
endmodule : hpp_port_properties

// >>> verif/tb_async_host_processor_port.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/10ps
module tb_async_host_processor_port;
  import hpp_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic style = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] addr = ADDR_ZERO;
  logic [DATA_W-1:0] wdata = DATA_ZERO;
  logic adone = 1'b0;
  logic [DATA_W-1:0] ardata = DATA_ZERO;
  logic busy, done, av, aw, am, exp_w;
  logic [DATA_W-1:0] rdata, awd, exp_d;
  logic [ADDR_W-1:0] aa, exp_a;
  logic [31:0] seed = 32'h96ee;
  logic [DATA_W-1:0] dev_mem [int];
  logic [DATA_W-1:0] shadow [int];
  int miscompares = 0;
  int checks_done = 0;
  int dly = 0;
  bit pend = 1'b0;
  hpp_if hif();
  hpp_host hpp_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_bus_style(style), .i_req(req),
    .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .port(hif.host));
  hpp_device hpp_device_i (.i_clk(i_clk), .i_reset(i_reset), .port(hif.device),
    .o_acc_valid(av), .o_acc_write(aw), .o_acc_mem(am), .o_acc_addr(aa),
    .o_acc_wdata(awd), .i_acc_done(adone), .i_acc_rdata(ardata));
  hpp_port_properties hpp_port_properties_i (.i_clk(i_clk), .i_reset(i_reset),
    .cs_n(hif.cs_n), .rw_wr_n(hif.rw_wr_n), .data_strobe_or_read_strobe_n(hif.data_strobe_or_read_strobe_n),
    .bus_style(hif.bus_style), .host_data_oe(hif.host_data_oe), .dev_data_o(hif.dev_data_o),
    .dev_data_oe(hif.dev_data_oe), .dev_ack_o(hif.dev_ack_o), .dev_ack_oe(hif.dev_ack_oe));
  // free-running clock
  always #4 i_clk = ~i_clk;
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  function automatic logic [DATA_W-1:0] init_val(input logic [ADDR_W-1:0] a);
    return {2'h0, a} ^ 16'h5a3c;
  endfunction : init_val
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // internal access responder, latency taken from the address
  always @(negedge i_clk)
  begin
    if (av === 1'b1)
    begin
      check("acc_addr", exp_a, aa);
      check("acc_write", exp_w, aw);
      check("acc_mem", exp_a[MEM_SEL_BIT], am);
      if (aw === 1'b1)
        check("acc_wdata", exp_d, awd);
      if (aw === 1'b1)
        dev_mem[aa] = awd;
      dly = aa[1:0];
      pend = 1'b1;
    end
    if (pend && dly == 0)
    begin
      adone <= 1'b1;
      ardata <= dev_mem.exists(aa) ? dev_mem[aa] : init_val(aa);
      pend = 1'b0;
    end
    else
    begin
      adone <= 1'b0;
      if (pend)
        dly--;
    end
  end
  // one host access, waits for completion and end of gap
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    exp_w = w;
    exp_a = a;
    exp_d = d;
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(negedge i_clk);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(negedge i_clk);
      n++;
    end
    check("done", 1, done);
    if (!w)
      check("rdata", shadow.exists(a) ? shadow[a] : init_val(a), rdata);
    if (w)
      shadow[a] = d;
    while (busy !== 1'b0 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    check("ack_idle", style, hif.transfer_acknowledge);
  endtask : access
  // main sequence: both bus styles, corners then random traffic
  initial
  begin
    logic [31:0] r;
    repeat (6) @(negedge i_clk);
    i_reset <= 1'b0;
    for (int s = 1; s >= 0; s--)
    begin
      style <= s[0];
      repeat (10) @(negedge i_clk);
      access(1'b1, 14'h0000, 16'hffff);
      access(1'b1, 14'h3fff, 16'h0001);
      access(1'b0, 14'h3fff, DATA_ZERO);
      access(1'b0, 14'h0000, DATA_ZERO);
      for (int k = 0; k < 24; k++)
      begin
        r = next_rand();
        access(r[5], r[29:16] & 14'h2007, r[31:16]);
      end
    end
    summarize();
  end
  // watchdog against a hung handshake
  initial
  begin
    #(8 * 20000);
    miscompares++;
    summarize();
  end
endmodule : tb_async_host_processor_port
